// ==== src/odt_term_pkg.sv ====
// constants and types of the termination timing control
package odt_term_pkg;

  localparam int CLK_PERIOD_PS = 10000;

  // asynchronous on / off delays, in ps as printed
  localparam int ASYNC_ON_MIN_PS  = 2000;
  localparam int ASYNC_ON_MAX_PS  = 8500;
  localparam int ASYNC_OFF_MIN_PS = 2000;
  localparam int ASYNC_OFF_MAX_PS = 8500;

  // not given: plain defaults
  localparam int REFRESH_CYCLE_TIME_PS = 260000;
  localparam int DLL_EXIT_DELAY_PS     = 24000;
  localparam int DLL_RESYNC_CYC        = 512;

  localparam int LAT_W       = 5;
  localparam int DELAY_DEPTH = 32;
  localparam int CNT_W       = 10;
  localparam int SYNC_LAT_SUB = 2;
  localparam int LEAD_SUB     = 1;
  localparam logic RST_TERM   = 1'b0;
  localparam logic RST_CKE    = 1'b1;

  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    cyc_up = (c < 1) ? 1 : c;
  endfunction : cyc_up

  function automatic int cyc_down(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    cyc_down = (c < 1) ? 1 : c;
  endfunction : cyc_down

  // least delay rounds up, longest rounds down; a 10 ns clock folds both to 1
  localparam int ASYNC_ON_CYC  =
    (cyc_up(ASYNC_ON_MIN_PS) > cyc_down(ASYNC_ON_MAX_PS))
    ? cyc_down(ASYNC_ON_MAX_PS) : cyc_up(ASYNC_ON_MIN_PS);
  localparam int ASYNC_OFF_CYC =
    (cyc_up(ASYNC_OFF_MIN_PS) > cyc_down(ASYNC_OFF_MAX_PS))
    ? cyc_down(ASYNC_OFF_MAX_PS) : cyc_up(ASYNC_OFF_MIN_PS);
  localparam int REFRESH_CYC   = cyc_up(REFRESH_CYCLE_TIME_PS);
  localparam int DLL_EXIT_CYC  = cyc_up(DLL_EXIT_DELAY_PS);

  typedef enum logic [1:0] {
    MODE_SYNC,
    MODE_ENTRY_REFRESH,
    MODE_ASYNC,
    MODE_EXIT
  } term_mode_type;

endpackage : odt_term_pkg

// ==== src/odt_delay_if.sv ====
// carrier between the controller and its delay line
`timescale 1ns/1ps
`default_nettype none
interface odt_delay_if;
  import odt_term_pkg::*;
  logic             odt;
  logic [LAT_W-1:0] on_tap;
  logic [LAT_W-1:0] off_tap;
  logic             on_tapped;
  logic             off_tapped;
  modport ctrl (output odt, output on_tap, output off_tap,
                input on_tapped, input off_tapped);
  modport line (input odt, input on_tap, input off_tap,
                output on_tapped, output off_tapped);
endinterface : odt_delay_if
`default_nettype wire

// ==== src/odt_delay_line.sv ====
// history of sampled termination request with two taps
`timescale 1ns/1ps
`default_nettype none
module odt_delay_line
  import odt_term_pkg::*;
#(
  parameter int DEPTH = DELAY_DEPTH
) (
  input  wire logic    sys_clk_i,
  input  wire logic    rst_i,
  odt_delay_if.line    dl
);
  import odt_term_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] hist;
  } line_state_type;

  line_state_type s_q;
  line_state_type s_d;

  // hist[k] is the request sampled k+1 edges ago
  always_comb begin
    s_d      = s_q;
    s_d.hist = {s_q.hist[DEPTH-2:0], dl.odt};
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dl.on_tapped  = s_q.hist[dl.on_tap];
  assign dl.off_tapped = s_q.hist[dl.off_tap];
endmodule : odt_delay_line
`default_nettype wire

// ==== src/odt_term_ctrl.sv ====
// on-die termination timing control, sync/async across power-down
// Notes on behaviour
// RULE1 - async timing in power-down with DLL off, if termination on
// RULE2 - async timing while the DLL resynchronises after a reset
// RULE3 - async mode ignores additive latency
// RULE4 - async turn-on between 2 ns and 8.5 ns after request sampled high; code turns on one 10 ns cycle after
// RULE5 - async turn-off between 2 ns and 8.5 ns after request sampled low; code turns off one 10 ns cycle after
// RULE6 - transition windows exist only when DLL is off in power-down
// RULE7 - entry window: lead time before enable low until it registers
// RULE8 - lead time is write latency minus one
// RULE9 - refresh in progress extends entry window to refresh cycle end
// RULE10 - entry window changes lie between async and sync bounds
// RULE11 - exit window: lead time before enable high, plus DLL exit delay
// RULE12 - exit window changes lie between async and sync bounds
// RULE13 - short enable-low pulse: either response, entry start to exit end
// RULE14 - short enable-high pulse: either response, exit start to entry end
// RULE15 - sync before entry, async after entry, sync after exit window
// RULE16 - sync on and off latency is write CAS plus additive minus two
// RULE17 - controller treats termination as uncertain inside windows
`timescale 1ns/1ps
`default_nettype none
module odt_term_ctrl
  import odt_term_pkg::*;
#(
  parameter int REFRESH_CYCLES  = REFRESH_CYC,
  parameter int DLL_EXIT_CYCLES = DLL_EXIT_CYC,
  parameter int RESYNC_CYCLES   = DLL_RESYNC_CYC
) (
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            odt_i,
  input  wire logic                            cke_i,
  input  wire logic                            banks_idle_i,
  input  wire logic                            refresh_cmd_i,
  input  wire logic                            dll_reset_i,
  input  wire logic                            dll_on_in_pd_i,
  input  wire logic                            nominal_term_en_i,
  input  wire logic                            write_term_en_i,
  input  wire logic [odt_term_pkg::LAT_W-1:0]  write_cas_latency_i,
  input  wire logic [odt_term_pkg::LAT_W-1:0]  additive_latency_i,
  output logic                                 term_on_o,
  output logic                                 async_mode_o,
  output logic                                 transition_o,
  output logic                                 dll_resync_o,
  output logic [odt_term_pkg::LAT_W-1:0]       lead_time_o
);
  import odt_term_pkg::*;

  typedef struct packed {
    term_mode_type    mode;
    logic             cke_prev;
    logic             term;
    logic             async;
    logic             trans;
    logic             resync;
    logic [CNT_W-1:0] refresh_cnt;
    logic [CNT_W-1:0] exit_cnt;
    logic [CNT_W-1:0] resync_cnt;
    logic [LAT_W-1:0] lead;
  } ctrl_state_type;

  ctrl_state_type s_q;
  ctrl_state_type s_d;

  odt_delay_if dl ();

  odt_delay_line #(
    .DEPTH (DELAY_DEPTH)
  ) u_line (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .dl        (dl)
  );

  function automatic logic [CNT_W-1:0] dec_cnt(input logic [CNT_W-1:0] c);
    dec_cnt = (c == '0) ? '0 : c - 1'b1;
  endfunction : dec_cnt

  logic [LAT_W:0]   write_latency;
  logic [LAT_W-1:0] sync_lat;
  logic             term_enabled;
  logic             pd_dll_off;
  logic             cke_fall;
  logic             cke_rise;
  logic             resyncing;

  always_comb begin
    write_latency = {1'b0, write_cas_latency_i} + {1'b0, additive_latency_i};
    // latency clamped at one; tiny settings are illegal anyway
    if (write_latency > (LAT_W+1)'(SYNC_LAT_SUB)) begin
      sync_lat = LAT_W'(write_latency - (LAT_W+1)'(SYNC_LAT_SUB)); // RULE16
    end else begin
      sync_lat = LAT_W'(1);
    end
    term_enabled = nominal_term_en_i | write_term_en_i;
    pd_dll_off   = ~dll_on_in_pd_i & term_enabled; // RULE6
    cke_fall     = s_q.cke_prev & ~cke_i;
    cke_rise     = ~s_q.cke_prev & cke_i;
    resyncing    = (s_q.resync_cnt != '0);
  end

  // taps pick the sync path or the fixed async delay
  always_comb begin
    dl.odt = odt_i;
    if (s_q.async) begin
      dl.on_tap  = LAT_W'(ASYNC_ON_CYC - 1);  // RULE3
      dl.off_tap = LAT_W'(ASYNC_OFF_CYC - 1);
    end else begin
      dl.on_tap  = sync_lat - 1'b1;
      dl.off_tap = sync_lat - 1'b1;
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.cke_prev = cke_i;
    s_d.lead     = sync_lat + LAT_W'(LEAD_SUB); // RULE8
    s_d.refresh_cnt = dec_cnt(s_q.refresh_cnt);
    s_d.exit_cnt    = dec_cnt(s_q.exit_cnt);
    s_d.resync_cnt  = dec_cnt(s_q.resync_cnt);
    if (refresh_cmd_i) begin
      s_d.refresh_cnt = CNT_W'(REFRESH_CYCLES);
    end
    if (dll_reset_i) begin
      s_d.resync_cnt = CNT_W'(RESYNC_CYCLES);
    end

    case (s_q.mode)
      MODE_SYNC: begin
        // lead part of entry window answers synchronously, a legal choice
        if (cke_fall && banks_idle_i && pd_dll_off) begin
          if (s_q.refresh_cnt > CNT_W'(1)) begin
            s_d.mode = MODE_ENTRY_REFRESH; // RULE9
          end else begin
            s_d.mode = MODE_ASYNC; // RULE7
          end
        end
      end
      MODE_ENTRY_REFRESH: begin
        // dll kept on mid-entry: skip power-down, go straight to the async exit window
        if (cke_rise || !pd_dll_off) begin
          s_d.mode     = MODE_EXIT; // RULE13 RULE6
          s_d.exit_cnt = CNT_W'(DLL_EXIT_CYCLES);
        end else if (s_q.refresh_cnt <= CNT_W'(1)) begin
          s_d.mode = MODE_ASYNC; // RULE9
        end
      end
      MODE_ASYNC: begin
        if (cke_rise || !pd_dll_off) begin
          s_d.mode     = MODE_EXIT; // RULE11
          s_d.exit_cnt = CNT_W'(DLL_EXIT_CYCLES);
        end
      end
      MODE_EXIT: begin
        // stays async until the DLL is back; refresh may still run
        if (cke_fall && banks_idle_i && pd_dll_off) begin
          s_d.mode = MODE_ASYNC; // RULE14
        end else if (s_q.exit_cnt <= CNT_W'(1)) begin
          s_d.mode = MODE_SYNC; // RULE15
        end
      end
      default: begin
        s_d.mode = MODE_SYNC;
      end
    endcase

    // async from entry end through power-down and exit window
    s_d.async = resyncing | dll_reset_i // RULE2
              | (s_d.mode == MODE_ASYNC) // RULE1
              | (s_d.mode == MODE_EXIT); // RULE15
    s_d.trans = (s_d.mode == MODE_ENTRY_REFRESH) | (s_d.mode == MODE_EXIT);
    s_d.resync = (s_d.resync_cnt != '0); // RULE2

    // both paths land inside the lesser/greater envelope
    if (!term_enabled) begin
      s_d.term = 1'b0;
    end else if (s_q.term) begin
      s_d.term = dl.off_tapped; // RULE5 RULE10 RULE12
    end else begin
      s_d.term = dl.on_tapped; // RULE4 RULE10 RULE12
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q             <= '0;
      s_q.mode        <= MODE_SYNC;
      s_q.cke_prev    <= RST_CKE;
      s_q.term        <= RST_TERM;
    end else begin
      s_q <= s_d;
    end
  end

  assign term_on_o    = s_q.term;
  assign async_mode_o = s_q.async;
  assign transition_o = s_q.trans;
  assign dll_resync_o = s_q.resync;
  assign lead_time_o  = s_q.lead;
endmodule : odt_term_ctrl
`default_nettype wire

// ==== bench/odt_term_chk.sv ====
// checker on the ports of the termination timing control
`timescale 1ns/1ps
`default_nettype none
module odt_term_chk
  import odt_term_pkg::*;
#(
  parameter int REFRESH_CYCLES  = REFRESH_CYC,
  parameter int DLL_EXIT_CYCLES = DLL_EXIT_CYC,
  parameter int RESYNC_CYCLES   = DLL_RESYNC_CYC
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_i,
  input wire logic             odt_i,
  input wire logic             cke_i,
  input wire logic             banks_idle_i,
  input wire logic             refresh_cmd_i,
  input wire logic             dll_reset_i,
  input wire logic             dll_on_in_pd_i,
  input wire logic             nominal_term_en_i,
  input wire logic             write_term_en_i,
  input wire logic [LAT_W-1:0] write_cas_latency_i,
  input wire logic [LAT_W-1:0] additive_latency_i,
  input wire logic             term_on_o,
  input wire logic             async_mode_o,
  input wire logic             transition_o,
  input wire logic             dll_resync_o,
  input wire logic [LAT_W-1:0] lead_time_o
);
  localparam int REF_MAX  = REFRESH_CYCLES + 2;
  localparam int EXIT_MAX = DLL_EXIT_CYCLES + 2;
  localparam int RS_MIN   = RESYNC_CYCLES - 2;
  localparam int RS_MAX   = RESYNC_CYCLES + 2;
  // odt history, bit 0 is the latest sample
  logic [31:0]      hist_q;
  logic [CNT_W-1:0] rf_q;
  wire en   = nominal_term_en_i | write_term_en_i;
  wire busy = refresh_cmd_i || rf_q != '0;
  wire [LAT_W-1:0] lat = write_cas_latency_i + additive_latency_i - 5'h2;
  wire [LAT_W-1:0] ld  = write_cas_latency_i + additive_latency_i - 5'h1;
  always_ff @(posedge sys_clk_i) begin
    hist_q <= {hist_q[30:0], odt_i};
    if (rst_i) rf_q <= '0;
    else if (refresh_cmd_i) rf_q <= CNT_W'(REFRESH_CYCLES - 1);
    else if (busy) rf_q <= rf_q - 1'b1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence pd_fall;
    $fell(cke_i) && banks_idle_i && !dll_on_in_pd_i && en
      && !async_mode_o && !transition_o;
  endsequence
  entry_async_a: assert property (pd_fall ##0 !busy |=>
    async_mode_o && !transition_o) else $error("entry not async");
  entry_refresh_a: assert property (pd_fall ##0 busy |=>
    (transition_o && !async_mode_o) ##[1:REF_MAX] async_mode_o)
    else $error("refresh entry wrong");
  exit_window_a: assert property ($rose(cke_i) && async_mode_o
    && !transition_o && !dll_resync_o |=> (async_mode_o && transition_o)
    ##[1:EXIT_MAX] !transition_o) else $error("exit window wrong");
  resync_a: assert property (dll_reset_i |-> ##2
    (async_mode_o && dll_resync_o) ##[RS_MIN:RS_MAX] !dll_resync_o)
    else $error("resync wrong");
  no_window_a: assert property (dll_on_in_pd_i [*8] |-> !transition_o)
    else $error("window with dll on");
  lead_time_a: assert property (!$past(rst_i)
    && $stable(write_cas_latency_i) && $stable(additive_latency_i)
    |-> lead_time_o == ld) else $error("lead time wrong");
  sync_latency_a: assert property (
    (!async_mode_o && !transition_o && !dll_resync_o && en) [*8]
    |-> term_on_o == hist_q[lat]) else $error("sync latency wrong");
  async_delay_a: assert property (
    (async_mode_o && !transition_o && en) [*3]
    |-> term_on_o == hist_q[1]) else $error("async delay wrong");
endmodule : odt_term_chk
bind odt_term_ctrl odt_term_chk #(
  .REFRESH_CYCLES (REFRESH_CYCLES),
  .DLL_EXIT_CYCLES(DLL_EXIT_CYCLES),
  .RESYNC_CYCLES  (RESYNC_CYCLES)
) u_odt_term_chk (
  .sys_clk_i           (sys_clk_i),
  .rst_i               (rst_i),
  .odt_i               (odt_i),
  .cke_i               (cke_i),
  .banks_idle_i        (banks_idle_i),
  .refresh_cmd_i       (refresh_cmd_i),
  .dll_reset_i         (dll_reset_i),
  .dll_on_in_pd_i      (dll_on_in_pd_i),
  .nominal_term_en_i   (nominal_term_en_i),
  .write_term_en_i     (write_term_en_i),
  .write_cas_latency_i (write_cas_latency_i),
  .additive_latency_i  (additive_latency_i),
  .term_on_o           (term_on_o),
  .async_mode_o        (async_mode_o),
  .transition_o        (transition_o),
  .dll_resync_o        (dll_resync_o),
  .lead_time_o         (lead_time_o)
);
`default_nettype wire

// ==== bench/odt_ctrl_model.sv ====
// controller model driving termination request and clock enable
`timescale 1ns/1ps
`default_nettype none
module odt_ctrl_model (
  input  wire logic sys_clk_i,
  input  wire logic want_odt_i,
  input  wire logic want_cke_i,
  output var logic  odt_o,
  output var logic  cke_o
);
  // state is not trusted inside windows, so no reliance there
  always @(posedge sys_clk_i) begin
    odt_o <= want_odt_i;
    cke_o <= want_cke_i;
  end
endmodule : odt_ctrl_model
`default_nettype wire

// ==== bench/tb_odt_term_ctrl.sv ====
// self-checking bench of the termination timing control
`timescale 1ns/1ps
`default_nettype none
module tb_odt_term_ctrl;
  import odt_term_pkg::*;
  localparam int RF = 4;
  localparam int DX = 2;
  localparam int RS = 8;
  logic clk, rst, odt_q, cke_q, idle, refr, dll_rst, dll_on, nom, wr;
  logic [LAT_W-1:0] write_cas_latency, al, lead;
  logic term, amode, trans, resync;
  wire odt, cke;
  int err_count, samples_checked, cyc;
  odt_ctrl_model u_odt_ctrl_model (.sys_clk_i(clk), .want_odt_i(odt_q),
    .want_cke_i(cke_q), .odt_o(odt), .cke_o(cke));
  odt_term_ctrl #(.REFRESH_CYCLES(RF), .DLL_EXIT_CYCLES(DX),
    .RESYNC_CYCLES(RS)) u_odt_term_ctrl (.sys_clk_i(clk), .rst_i(rst),
    .odt_i(odt), .cke_i(cke), .banks_idle_i(idle), .refresh_cmd_i(refr),
    .dll_reset_i(dll_rst), .dll_on_in_pd_i(dll_on),
    .nominal_term_en_i(nom), .write_term_en_i(wr),
    .write_cas_latency_i(write_cas_latency), .additive_latency_i(al),
    .term_on_o(term), .async_mode_o(amode), .transition_o(trans),
    .dll_resync_o(resync), .lead_time_o(lead));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run needs about 160 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic go(input logic c, input logic o, input int n);
    cke_q = c;
    odt_q = o;
    repeat (n) @(posedge clk);
    #1;
  endtask : go
  task automatic chk(input string what, input logic [LAT_W-1:0] exp,
                     input logic [LAT_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_pair(input string what, input logic [1:0] exp,
                          input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_pair
  // model adds one cycle, so answers land one edge later
  task automatic t_sync(input logic [LAT_W-1:0] a);
    int l;
    go(1'b1, 1'b0, 8);
    al = a;
    l = int'(write_cas_latency + a) - 2;
    go(1'b1, 1'b1, l + 1);
    chk("lead", write_cas_latency + a - 5'h1, lead);
    chk_bit("term", 1'b0, term);
    go(1'b1, 1'b1, 1);
    chk_bit("term", 1'b1, term);
    go(1'b1, 1'b0, l + 1);
    chk_bit("term", 1'b1, term);
    go(1'b1, 1'b0, 1);
    chk_bit("term", 1'b0, term);
  endtask : t_sync
  task automatic t_pd;
    go(1'b0, 1'b0, 2);
    chk_pair("mode", 2'h2, {amode, trans});
    go(1'b0, 1'b1, 2);
    chk_bit("term", 1'b0, term);
    go(1'b0, 1'b1, 1);
    chk_bit("term", 1'b1, term);
    go(1'b0, 1'b0, 2);
    chk_bit("term", 1'b1, term);
    go(1'b0, 1'b0, 1);
    chk_bit("term", 1'b0, term);
    go(1'b1, 1'b0, 2);
    chk_pair("mode", 2'h3, {amode, trans});
    go(1'b1, 1'b0, DX + 2);
    chk_pair("mode", 2'h0, {amode, trans});
  endtask : t_pd
  task automatic t_ref;
    refr = 1'b1;
    go(1'b1, 1'b0, 1);
    refr = 1'b0;
    go(1'b0, 1'b0, 3);
    chk_pair("mode", 2'h1, {amode, trans});
    go(1'b0, 1'b0, RF + 1);
    chk_pair("mode", 2'h2, {amode, trans});
    go(1'b1, 1'b0, DX + 4);
  endtask : t_ref
  task automatic t_misc;
    // open bank at enable fall: active power-down stays synchronous
    idle = 1'b0;
    go(1'b0, 1'b0, 4);
    chk_pair("mode", 2'h0, {amode, trans});
    go(1'b1, 1'b0, 2);
    idle = 1'b1;
    dll_on = 1'b1;
    go(1'b0, 1'b0, 4);
    chk_pair("mode", 2'h0, {amode, trans});
    go(1'b1, 1'b0, 2);
    dll_on = 1'b0;
    dll_rst = 1'b1;
    go(1'b1, 1'b0, 1);
    dll_rst = 1'b0;
    go(1'b1, 1'b0, 1);
    chk_pair("resync", 2'h3, {amode, resync});
    go(1'b1, 1'b0, RS + 2);
    chk_pair("resync", 2'h0, {amode, resync});
    nom = 1'b0;
    go(1'b1, 1'b1, 8);
    chk_bit("term", 1'b0, term);
    wr = 1'b1;
    go(1'b1, 1'b1, 8);
    chk_bit("term", 1'b1, term);
    go(1'b1, 1'b0, 8);
  endtask : t_misc
  task automatic t_short;
    go(1'b0, 1'b0, 1);
    go(1'b1, 1'b0, DX + 6);
    chk_pair("mode", 2'h0, {amode, trans});
    go(1'b0, 1'b0, 3);
    go(1'b1, 1'b0, 1);
    go(1'b0, 1'b0, 6);
    chk_pair("mode", 2'h2, {amode, trans});
    go(1'b1, 1'b0, DX + 6);
    // short low pulse while a refresh still runs
    refr = 1'b1;
    go(1'b1, 1'b0, 1);
    refr = 1'b0;
    go(1'b0, 1'b0, 1);
    go(1'b1, 1'b0, 2);
    chk_pair("mode", 2'h3, {amode, trans});
    go(1'b1, 1'b0, DX + 4);
    chk_pair("mode", 2'h0, {amode, trans});
  endtask : t_short
  initial begin
    rst = 1'b1;
    idle = 1'b1;
    refr = 1'b0;
    dll_rst = 1'b0;
    dll_on = 1'b0;
    nom = 1'b1;
    wr = 1'b0;
    write_cas_latency = 5'h5;
    al = 5'h0;
    go(1'b1, 1'b0, 6);
    chk_pair("mode", 2'h0, {amode, trans});
    rst = 1'b0;
    go(1'b1, 1'b0, 2);
    chk("lead", write_cas_latency + al - 5'h1, lead);
    t_sync(5'h0);
    t_sync(5'h2);
    t_pd();
    t_ref();
    t_misc();
    t_short();
    end_sim();
  end
endmodule : tb_odt_term_ctrl
`default_nettype wire
